// ### core/pdf_post_divider.sv
`timescale 1ns/10ps
`include "pdf_params.svh"

// Operation
// - Mode field all ones turns the output into a frame pulse set by the low twenty bits.
// - Any other mode value makes the whole 24-bit value a VCO divide ratio near 50% duty.
// - Frame pulses are spaced by the 16-bit period count of related-clock periods.
// - Select code 00 picks postdivider A, 01 picks B, 10 picks C, and 11 is reserved.
// - Each frame pulse is exactly one related-clock period wide for period counts above 1; a count of 1 holds it asserted.
// - Polarity bit 0 gives a regular pulse and 1 an inverted pulse.
// - Type bit 0 centres the frame boundary in the pulse, 1 puts it on the pulse edge.
// - Even ratios keep duty cycle within 45% to 55%; small odd ratios may stray.
module pdf_post_divider
  import pdf_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  // Register access
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Clock sources
  input  wire logic       VCO_TICK,
  input  wire logic       RELATED_A,
  input  wire logic       RELATED_B,
  input  wire logic       RELATED_C,
  // Output stage
  output logic            OUT_D,
  output logic            FRAME_MODE
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [23:0]   setup_r;
  logic [23:0]   setup_nxt;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;
  pdf_setup_type cfg;
  logic [23:0]   div_cnt_r;
  logic [23:0]   div_cnt_nxt;
  logic [15:0]   frm_cnt_r;
  logic [15:0]   frm_cnt_nxt;
  logic          rel_prev_r;
  logic          rel_prev_nxt;
  logic          pulse_r;
  logic          pulse_nxt;
  logic          out_r;
  logic          out_nxt;
  logic          mode_r;
  logic          mode_nxt;
  pdf_state_type state_r;
  pdf_state_type state_nxt;
  logic          rel_clk;
  logic          rel_rise;
  logic          rel_fall;
  logic          rel_valid;
  logic [23:0]   half;
  logic [15:0]   last;

  assign cfg        = pdf_setup_type'(setup_r);
  assign REG_RDATA  = rdata_r;
  assign OUT_D      = out_r;
  assign FRAME_MODE = mode_r;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb
  begin
    setup_nxt = setup_r;
    rdata_nxt = rdata_r;
    if (REG_WR && REG_ADDR == `PDF_ADDR_HI)
      setup_nxt[23:16] = REG_WDATA;
    else if (REG_WR && REG_ADDR == `PDF_ADDR_MID)
      setup_nxt[15:8] = REG_WDATA;
    else if (REG_WR && REG_ADDR == `PDF_ADDR_LO)
      setup_nxt[7:0] = REG_WDATA;
    if (REG_RD && REG_ADDR == `PDF_ADDR_HI)
      rdata_nxt = setup_r[23:16];
    else if (REG_RD && REG_ADDR == `PDF_ADDR_MID)
      rdata_nxt = setup_r[15:8];
    else if (REG_RD && REG_ADDR == `PDF_ADDR_LO)
      rdata_nxt = setup_r[7:0];
    else if (REG_RD)
      rdata_nxt = 8'h00;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      setup_r <= `PDF_RESET_VALUE;
      rdata_r <= 8'h00;
    end
    else
    begin
      setup_r <= setup_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Related clock select and edges
  // ----------------------------------------
  always_comb
  begin
    rel_valid = 1'b1;
    if (cfg.rel_sel == `PDF_SEL_A)
      rel_clk = RELATED_A;
    else if (cfg.rel_sel == `PDF_SEL_B)
      rel_clk = RELATED_B;
    else if (cfg.rel_sel == `PDF_SEL_C)
      rel_clk = RELATED_C;
    else
    begin
      rel_clk   = 1'b0;
      rel_valid = 1'b0;
    end
  end

  assign rel_rise = rel_clk && !rel_prev_r;
  assign rel_fall = !rel_clk && rel_prev_r;
  assign half     = {1'b0, setup_r[23:1]};
  assign last     = cfg.period - 16'h0001;

  // ----------------------------------------
  // Divider and frame pulse
  // ----------------------------------------
  always_comb
  begin
    state_nxt    = state_r;
    div_cnt_nxt  = div_cnt_r;
    frm_cnt_nxt  = frm_cnt_r;
    pulse_nxt    = pulse_r;
    out_nxt      = out_r;
    rel_prev_nxt = rel_clk;
    mode_nxt     = (cfg.mode == `PDF_MODE_FRAME);
    if (cfg.mode == `PDF_MODE_FRAME)
      state_nxt = (rel_valid && cfg.period != 16'h0000) ? PDF_FRAME : PDF_IDLE;
    else
      state_nxt = (setup_r != 24'h000000) ? PDF_DIV : PDF_IDLE;
    case (state_r)
      PDF_DIV:
      begin
        frm_cnt_nxt = 16'h0000;
        pulse_nxt   = 1'b0;
        if (VCO_TICK)
        begin
          if (div_cnt_r >= setup_r - 24'h000001)
            div_cnt_nxt = 24'h000000;
          else
            div_cnt_nxt = div_cnt_r + 24'h000001;
        end
        // High for the first half; exact for even ratios
        if (setup_r == 24'h000001)
          out_nxt = VCO_TICK ? !out_r : out_r;
        else
          out_nxt = (div_cnt_r < half);
      end
      PDF_FRAME:
      begin
        div_cnt_nxt = 24'h000000;
        if (rel_rise)
        begin
          if (frm_cnt_r >= last)
            frm_cnt_nxt = 16'h0000;
          else
            frm_cnt_nxt = frm_cnt_r + 16'h0001;
        end
        if (cfg.pulse_type)
        begin
          // Boundary on the leading edge: rise to rise
          if (rel_rise)
            pulse_nxt = (frm_cnt_r >= last);
        end
        else if (rel_fall)
          // Boundary in the middle: fall to fall around it
          pulse_nxt = (frm_cnt_r >= last);
        out_nxt = pulse_nxt ^ cfg.polarity;
      end
      default:
      begin
        div_cnt_nxt = 24'h000000;
        frm_cnt_nxt = 16'h0000;
        pulse_nxt   = 1'b0;
        out_nxt     = (cfg.mode == `PDF_MODE_FRAME) ? cfg.polarity : 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_r    <= PDF_IDLE;
      div_cnt_r  <= 24'h000000;
      frm_cnt_r  <= 16'h0000;
      rel_prev_r <= 1'b0;
      pulse_r    <= 1'b0;
      out_r      <= 1'b0;
      mode_r     <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      div_cnt_r  <= div_cnt_nxt;
      frm_cnt_r  <= frm_cnt_nxt;
      rel_prev_r <= rel_prev_nxt;
      pulse_r    <= pulse_nxt;
      out_r      <= out_nxt;
      mode_r     <= mode_nxt;
    end
  end

endmodule

// ### core/pdf_params.svh
`ifndef PDF_PARAMS_SVH
`define PDF_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PDF_ADDR_HI        8'hA1
`define PDF_ADDR_MID       8'hA2
`define PDF_ADDR_LO        8'hA3
`define PDF_RESET_VALUE    24'h000000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDF_MODE_MSB       23
`define PDF_MODE_LSB       20
`define PDF_TYPE_BIT       19
`define PDF_POLAR_BIT      18
`define PDF_SEL_MSB        17
`define PDF_SEL_LSB        16
`define PDF_PERIOD_MSB     15
`define PDF_PERIOD_LSB     0
`define PDF_MODE_FRAME     4'hF

// ----------------------------------------
// Related clock select codes
// ----------------------------------------
`define PDF_SEL_A          2'h0
`define PDF_SEL_B          2'h1
`define PDF_SEL_C          2'h2

`endif

// ### core/pdf_pkg.sv
package pdf_pkg;

  // ----------------------------------------
  // Register image as fields
  // ----------------------------------------
  typedef struct packed {
    logic [3:0]  mode;
    logic        pulse_type;
    logic        polarity;
    logic [1:0]  rel_sel;
    logic [15:0] period;
  } pdf_setup_type;

  typedef enum logic [1:0] {
    PDF_IDLE  = 2'b00,
    PDF_DIV   = 2'b01,
    PDF_FRAME = 2'b10
  } pdf_state_type;

endpackage

// ### bench/pdf_post_divider_properties.sv
`timescale 1ns/10ps
module pdf_post_divider_checker
(
  // Clock, reset and register bus
  input wire logic       CLK, RESET_N, REG_WR, REG_RD,
  input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
  // Sources and outputs
  input wire logic       VCO_TICK, RELATED_A, RELATED_B, RELATED_C, OUT_D, FRAME_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic rst_seen_r;
  always_ff @(posedge CLK)
    rst_seen_r <= !RESET_N;
  // --------
  // Checks
  // --------
  property p_rst;
    disable iff (1'b0) rst_seen_r && !RESET_N |-> !OUT_D && !FRAME_MODE && REG_RDATA == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
  property p_unmap;
    REG_RD && (REG_ADDR < 8'hA1 || REG_ADDR > 8'hA3) |=> REG_RDATA == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold;
    !REG_RD |=> $stable(REG_RDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_back;
    REG_WR && REG_ADDR == 8'hA2 ##1 !REG_WR ##1 REG_RD && REG_ADDR == 8'hA2
      |=> REG_RDATA == $past(REG_WDATA, 3);
  endproperty
  a_back: assert property (p_back) else $error("read back differs");
  property p_fon;
    REG_WR && REG_ADDR == 8'hA1 && REG_WDATA[7:4] == 4'hF |-> ##[1:2] FRAME_MODE;
  endproperty
  a_fon: assert property (p_fon) else $error("frame mode not entered");
  property p_foff;
    REG_WR && REG_ADDR == 8'hA1 && REG_WDATA[7:4] != 4'hF |-> ##[1:2] !FRAME_MODE;
  endproperty
  a_foff: assert property (p_foff) else $error("frame mode not left");
  property p_dstill;
    (!FRAME_MODE && !VCO_TICK && !REG_WR)[*4] |=> $stable(OUT_D);
  endproperty
  a_dstill: assert property (p_dstill) else $error("divider moved without tick");
  property p_fstill;
    (FRAME_MODE && !REG_WR && $stable({RELATED_A, RELATED_B, RELATED_C}))[*3]
      |=> $stable(OUT_D);
  endproperty
  a_fstill: assert property (p_fstill) else $error("pulse moved without edge");
  c_frame: cover property ($rose(FRAME_MODE));
  c_pulse: cover property (FRAME_MODE && $rose(OUT_D));
  c_div: cover property (!FRAME_MODE && $rose(OUT_D));
endmodule

// ### bench/pdf_post_divider_tb.sv
`timescale 1ns/10ps
`include "pdf_params.svh"
module pdf_post_divider_tb
  import pdf_pkg::*;
;
  logic          CLK = 0, RESET_N = 0, REG_WR = 0, REG_RD = 0, VCO_TICK = 0;
  logic          RELATED_A = 0, RELATED_B = 0, RELATED_C = 0, p, lp;
  logic [7:0]    REG_ADDR = 8'h00, REG_WDATA = 8'h00;
  logic [2:0]    rc = 3'h0;
  logic [1:0]    sel_drv = 2'h0;
  wire  [7:0]    REG_RDATA;
  wire           OUT_D, FRAME_MODE;
  int            err_count = 0, cmp_count = 0, hi;
  int            rl[4] = '{0, 6, 7, 8};
  logic [23:0]   rs[2] = '{24'h000004, 24'h000001};
  pdf_setup_type cfg;
  pdf_post_divider u_pdf_post_divider (.CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .VCO_TICK(VCO_TICK), .RELATED_A(RELATED_A), .RELATED_B(RELATED_B),
    .RELATED_C(RELATED_C), .OUT_D(OUT_D), .FRAME_MODE(FRAME_MODE));
  always #10 CLK = ~CLK;
  always @(posedge CLK)
  begin
    rc <= rc + 3'h1;
    RELATED_A <= rc[2] & (sel_drv == `PDF_SEL_A);
    RELATED_B <= rc[2] & (sel_drv == `PDF_SEL_B);
    RELATED_C <= rc[2] & (sel_drv == `PDF_SEL_C);
  end
  // --------
  // Tasks
  // --------
  task chk(input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
    #1 chk(REG_RDATA, e);
  endtask
  task set(input logic [23:0] v);
    wr(`PDF_ADDR_HI, v[23:16]);
    wr(`PDF_ADDR_MID, v[15:8]);
    wr(`PDF_ADDR_LO, v[7:0]);
  endtask
  task end_of_test;
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_regs;
    rd(`PDF_ADDR_HI, 8'h00);
    rd(`PDF_ADDR_LO, 8'h00);
    wr(`PDF_ADDR_MID, 8'h5A);
    rd(`PDF_ADDR_MID, 8'h5A);
    wr(8'hA0, 8'hFF);
    rd(8'hA4, 8'h00);
    rd(`PDF_ADDR_HI, 8'h00);
  endtask
  task t_div;
    VCO_TICK <= 1'b1;
    foreach (rl[i])
    begin
      set({16'h0000, rl[i][7:0]});
      repeat (20) @(posedge CLK);
      hi = 0;
      repeat (168)
      begin
        @(posedge CLK);
        #1 if (OUT_D === 1'b1) hi++;
      end
      chk(hi[7:0], 8'(rl[i] ? 168 / rl[i] * (rl[i] / 2) : 0));
      chk(8'(FRAME_MODE), 8'h00);
    end
    VCO_TICK <= 1'b0;
    foreach (rs[i])
    begin
      set(rs[i]);
      hi = 0;
      for (int n = 0; n < 120; n++)
      begin
        @(posedge CLK);
        VCO_TICK <= (n % 5 == 0);
        #1 if (n >= 40 && OUT_D === 1'b1) hi++;
      end
      chk(hi[7:0], 8'h28);
    end
  endtask
  task t_frame;
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 4; k++)
      begin
        cfg = '{4'hF, k[1], k[0], (s == 3) ? 2'h0 : s[1:0],
                (s == 3) ? 16'h0000 : 16'h0003};
        sel_drv <= s[1:0];
        set(cfg);
        repeat (30) @(posedge CLK);
        #1 chk(8'(FRAME_MODE), 8'h01);
        hi = 0;
        lp = OUT_D ^ cfg.polarity;
        repeat (48)
        begin
          @(posedge CLK);
          #1 p = OUT_D ^ cfg.polarity;
          if (p === 1'b1) hi++;
          if (p && !lp)
            chk(8'(RELATED_A | RELATED_B | RELATED_C), 8'(cfg.pulse_type));
          lp = p;
        end
        chk(hi[7:0], 8'(s < 3 ? 16 : 0));
      end
  endtask
  // --------
  // Sequence
  // --------
  initial
  begin
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    t_regs;
    t_div;
    t_frame;
    end_of_test;
  end
  initial
  begin
    repeat (20000) @(posedge CLK);
    err_count++;
    end_of_test;
  end
endmodule
bind pdf_post_divider pdf_post_divider_checker u_pdf_post_divider_checker (.CLK(CLK),
  .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .VCO_TICK(VCO_TICK), .RELATED_A(RELATED_A),
  .RELATED_B(RELATED_B), .RELATED_C(RELATED_C), .OUT_D(OUT_D), .FRAME_MODE(FRAME_MODE));
